// ---- hdl/spic_top.sv ----
// Sampled proportional-integral controller, top level
// Assumes synchronous configuration inputs held stable by the user
`timescale 1ns/1ps
`default_nettype none
module spic_top #(
    parameter int unsigned SAMPLE_DIV = spic_pkg::SAMPLE_CYCLES
) (
    // Clock and reset
    input  wire logic                             ref_clk,
    input  wire logic                             reset_n,
    // Process input and scaling
    input  wire logic signed [spic_pkg::DW-1:0]    process_value,
    input  wire logic signed [spic_pkg::DW-1:0]    proc_gain,
    input  wire logic signed [spic_pkg::DW-1:0]    proc_offset,
    input  wire logic signed [spic_pkg::DW-1:0]    proc_min,
    input  wire logic signed [spic_pkg::DW-1:0]    proc_max,
    input  wire logic signed [spic_pkg::DW-1:0]    setpoint,
    // Controller tuning
    input  wire logic [spic_pkg::GAIN_W-1:0]       loop_gain,
    input  wire logic [spic_pkg::ITIME_W-1:0]      integral_time,
    input  wire logic                             action_direction,
    input  wire logic [spic_pkg::PSET_W-1:0]       preset_sel,
    input  wire logic [spic_pkg::OUT_W-1:0]        manual_output_value,
    // Mode control
    input  wire logic                             auto_manual_select,
    input  wire logic                             output_reset,
    // Outputs
    output var  logic [spic_pkg::OUT_W-1:0]        analog_output,
    output var  logic                             auto_active,
    output var  logic                             sample_done
);
    import spic_pkg::*;

    // ---------------------------------------------------------------
    // Types and state
    // ---------------------------------------------------------------
    typedef struct packed {
        spic_mode_t              mode;
        logic signed [INT_W-1:0] integ;  // integral sum, FRAC fraction bits
        logic [OUT_W-1:0]        out;
        logic                    auto_on;
        logic                    done;
    } spic_core_state_t;

    localparam logic signed [INT_W-1:0] INT_MAX =
        INT_W'(OUT_MAX) <<< FRAC;

    spic_core_state_t state;
    spic_core_state_t next_state;

    spic_link_if link ();

    // ---------------------------------------------------------------
    // Sample divider and process scaling
    // ---------------------------------------------------------------
    spic_tick #(
        .DIV (SAMPLE_DIV)
    ) u_tick (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .link    (link.tick)
    );

    spic_scale u_scale (
        .ref_clk       (ref_clk),
        .reset_n       (reset_n),
        .process_value (process_value),
        .proc_gain     (proc_gain),
        .proc_offset   (proc_offset),
        .proc_min      (proc_min),
        .proc_max      (proc_max),
        .setpoint      (setpoint),
        .link          (link.scale)
    );

    // ---------------------------------------------------------------
    // Tuning selection
    // ---------------------------------------------------------------
    // Returns {upward, gain, integral time} for the selected preset
    function automatic logic [GAIN_W+ITIME_W:0] tune_lookup(
        input logic [PSET_W-1:0]  sel,
        input logic [GAIN_W-1:0]  gain,
        input logic [ITIME_W-1:0] itime,
        input logic               up);
        case (spic_preset_t'(sel))
            PS_TEMP_FAST:   return {1'b1, GAIN_TEMP_FAST, ITIME_TEMP_FAST};
            PS_TEMP_SLOW:   return {1'b1, GAIN_TEMP_SLOW, ITIME_TEMP_SLOW};
            PS_PRESS_QUICK: return {1'b1, GAIN_PRESS_QUICK,
                                    ITIME_PRESS_QUICK};
            PS_PRESS_SLOW:  return {1'b1, GAIN_PRESS_SLOW, ITIME_PRESS_SLOW};
            PS_LVL_NODRAIN: return {1'b1, GAIN_LVL_NODRAIN,
                                    ITIME_LVL_NODRAIN};
            PS_LVL_DRAIN:   return {1'b1, GAIN_LVL_DRAIN, ITIME_LVL_DRAIN};
            default:        return {up, gain, itime};
        endcase
    endfunction

    logic                    act_up;
    logic [GAIN_W-1:0]       act_gain;
    logic [ITIME_W-1:0]      act_itime;
    logic [OUT_W-1:0]        manual_q;
    logic                    calc;
    logic signed [ACC_W-1:0] err_eff;
    logic signed [ACC_W-1:0] kp;
    logic signed [ACC_W-1:0] ki;
    logic signed [ACC_W-1:0] itime_eff;
    logic signed [ACC_W-1:0] prop;
    logic signed [ACC_W-1:0] inc;
    logic signed [ACC_W-1:0] integ_new;
    logic signed [ACC_W-1:0] mv;

    // Preset decode and manual value bound
    always_comb begin
        {act_up, act_gain, act_itime} = tune_lookup(preset_sel, loop_gain,
            integral_time, action_direction);
        manual_q = (manual_output_value > OUT_MAX) ? OUT_MAX
                                                   : manual_output_value;
    end

    // ---------------------------------------------------------------
    // PI arithmetic
    // ---------------------------------------------------------------
    // One sample step: proportional, integral and manipulated variable
    always_comb begin
        calc = link.strobe && !output_reset && auto_manual_select
            && state.mode == ST_AUTO && link.loop_err != '0;
        // Downward action negates the loop error
        err_eff = act_up ? ACC_W'(link.loop_err)
                         : -ACC_W'(link.loop_err);
        kp = $signed(ACC_W'(act_gain));
        // Zero gain switches off the P part; I part then runs at unity
        ki = (act_gain == '0) ? $signed(ACC_W'(KI_UNITY)) : kp;
        itime_eff = (act_itime == '0) ? $signed(ACC_W'(ITIME_MIN))
                                      : $signed(ACC_W'(act_itime));
        prop = kp * err_eff / ACC_W'(GAIN_DIV);
        // Signed casts keep a negative error from going unsigned
        inc = (ki * err_eff * $signed(ACC_W'(TS_MS)) <<< FRAC)
            / (ACC_W'(GAIN_DIV) * $signed(ACC_W'(MS_PER_S))
               * itime_eff);
        integ_new = spic_clamp(ACC_W'(state.integ) + inc, '0,
                               ACC_W'(INT_MAX));
        mv = spic_clamp(prop + (integ_new >>> FRAC), '0,
                        ACC_W'(OUT_MAX));
    end

    // ---------------------------------------------------------------
    // Mode sequencing
    // ---------------------------------------------------------------
    // Reset wins; otherwise act only on the sample strobe
    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        if (output_reset) begin
            next_state.mode    = ST_RESET;
            next_state.out     = '0;
            next_state.integ   = '0;
            next_state.auto_on = 1'b0;
        end else if (link.strobe) begin
            case (state.mode)
                ST_AUTO: begin
                    if (!auto_manual_select) begin
                        next_state.mode    = ST_MANUAL;
                        next_state.out     = manual_q;
                        next_state.integ   = INT_W'(manual_q) <<< FRAC;
                        next_state.auto_on = 1'b0;
                    end else if (calc) begin
                        next_state.integ = INT_W'(integ_new);
                        next_state.out   = OUT_W'(mv);
                        next_state.done  = 1'b1;
                    end else begin
                        next_state.done  = 1'b1;
                    end
                end
                ST_RESET, ST_MANUAL: begin
                    if (auto_manual_select) begin
                        next_state.mode    = ST_AUTO;
                        next_state.integ   = INT_W'(manual_q) <<< FRAC;
                        next_state.out     = manual_q;
                        next_state.auto_on = 1'b1;
                    end else begin
                        next_state.mode    = ST_MANUAL;
                        next_state.out     = manual_q;
                        next_state.integ   = INT_W'(manual_q) <<< FRAC;
                    end
                end
                default: begin
                    next_state.mode = ST_RESET;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= '{mode: ST_RESET, default: '0};
        end else begin
            state <= next_state;
        end
    end

    assign analog_output = state.out;
    assign auto_active   = state.auto_on;
    assign sample_done   = state.done;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_reset_zero: assert property (
        output_reset |=> analog_output == '0)
        else $error("output not zero under output reset");
    a_reset_mode: assert property (
        output_reset |=> !auto_active && state.mode == ST_RESET)
        else $error("mode select acted under output reset");
    a_out_range: assert property (
        analog_output <= OUT_MAX)
        else $error("output beyond range");
    a_manual_out: assert property (
        link.strobe && !output_reset && !auto_manual_select
        |=> analog_output == $past(manual_q) && !sample_done)
        else $error("manual mode output wrong");
    a_auto_seed: assert property (
        link.strobe && !output_reset && auto_manual_select
        && state.mode != ST_AUTO
        |=> auto_active && state.integ == (INT_W'($past(manual_q)) <<< FRAC))
        else $error("integral sum not seeded on entry to automatic");
    a_equal_hold: assert property (
        link.strobe && !output_reset && auto_manual_select
        && state.mode == ST_AUTO && link.loop_err == '0
        |=> $stable(analog_output))
        else $error("output moved at zero loop error");
    a_dir_up: assert property (
        calc && act_up && link.loop_err < 0
        |=> state.integ <= $past(state.integ))
        else $error("upward action raised the integral sum");
    a_dir_down: assert property (
        calc && !act_up && link.loop_err < 0
        |=> state.integ >= $past(state.integ))
        else $error("downward action lowered the integral sum");
    a_strobe_only: assert property (
        !link.strobe && !output_reset |=> $stable(analog_output))
        else $error("output changed between samples");
    a_windup: assert property (
        state.integ >= 0 && state.integ <= INT_MAX)
        else $error("integral sum out of range");
    a_sum_form: assert property (
        calc |=> analog_output == OUT_W'($past(mv)))
        else $error("output is not P part plus integral sum");

    c_enter_auto: cover property (
        state.mode == ST_MANUAL ##1 state.mode == ST_AUTO);
    c_calc_down: cover property (calc && !act_up);
    c_reset_auto: cover property (state.mode == ST_AUTO && output_reset);
    c_out_full: cover property (analog_output == OUT_MAX);

endmodule // spic_top
`default_nettype wire

// ---- hdl/spic_pkg.sv ----
// Shared constants, types and helpers of the sampled PI controller
// Assumes a 25 MHz system clock and signed 16-bit internal process units
package spic_pkg;

    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int DW      = 16;  // process, setpoint, limits
    localparam int OUT_W   = 10;  // output range 0..1000
    localparam int GAIN_W  = 14;  // loop gain in hundredths
    localparam int ITIME_W = 13;  // integral time in seconds
    localparam int PSET_W  = 3;   // preset selector
    localparam int ACC_W   = 48;  // arithmetic width
    localparam int FRAC    = 8;   // fraction bits of the integral sum
    localparam int INT_W   = 24;  // integral sum width

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned TS_MS         = 500;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned SAMPLE_CYCLES = CLK_HZ / MS_PER_S * TS_MS;

    // ---------------------------------------------------------------
    // Scaling and limits
    // ---------------------------------------------------------------
    localparam int GAIN_DIV = 100;  // gains carried in hundredths
    localparam logic [OUT_W-1:0]   OUT_MAX   = 10'h3E8;
    localparam logic [GAIN_W-1:0]  KI_UNITY  = 14'h0064;
    localparam logic [ITIME_W-1:0] ITIME_MIN = 13'h0001;

    // ---------------------------------------------------------------
    // Presets: gain in hundredths, integral time in seconds
    // ---------------------------------------------------------------
    localparam logic [GAIN_W-1:0]  GAIN_TEMP_FAST   = 14'h0032;
    localparam logic [ITIME_W-1:0] ITIME_TEMP_FAST  = 13'h001E;
    localparam logic [GAIN_W-1:0]  GAIN_TEMP_SLOW   = 14'h0064;
    localparam logic [ITIME_W-1:0] ITIME_TEMP_SLOW  = 13'h0078;
    localparam logic [GAIN_W-1:0]  GAIN_PRESS_QUICK = 14'h012C;
    localparam logic [ITIME_W-1:0] ITIME_PRESS_QUICK = 13'h0005;
    localparam logic [GAIN_W-1:0]  GAIN_PRESS_SLOW  = 14'h0078;
    localparam logic [ITIME_W-1:0] ITIME_PRESS_SLOW = 13'h000C;
    localparam logic [GAIN_W-1:0]  GAIN_LVL_NODRAIN = 14'h0064;
    localparam logic [ITIME_W-1:0] ITIME_LVL_NODRAIN = 13'h0001;
    localparam logic [GAIN_W-1:0]  GAIN_LVL_DRAIN   = 14'h0046;
    localparam logic [ITIME_W-1:0] ITIME_LVL_DRAIN  = 13'h0014;

    typedef enum logic [PSET_W-1:0] {
        PS_CUSTOM, PS_TEMP_FAST, PS_TEMP_SLOW, PS_PRESS_QUICK,
        PS_PRESS_SLOW, PS_LVL_NODRAIN, PS_LVL_DRAIN
    } spic_preset_t;

    typedef enum logic [1:0] {ST_RESET, ST_MANUAL, ST_AUTO} spic_mode_t;

    // Saturate a value into [lo, hi]
    function automatic logic signed [ACC_W-1:0] spic_clamp(
        input logic signed [ACC_W-1:0] v,
        input logic signed [ACC_W-1:0] lo,
        input logic signed [ACC_W-1:0] hi);
        if (v > hi) begin
            return hi;
        end
        if (v < lo) begin
            return lo;
        end
        return v;
    endfunction

endpackage

// ---- hdl/spic_link_if.sv ----
// Internal link between sample divider, scaler and controller core
// Assumes all parties run on the one system clock
`timescale 1ns/1ps
`default_nettype none
interface spic_link_if;
    import spic_pkg::*;
    logic                 strobe;       // one-cycle sample tick
    logic signed [DW-1:0] scaled_proc;  // scaled, clamped process value
    logic signed [DW:0]   loop_err;     // setpoint minus scaled value
    modport tick  (output strobe);
    modport scale (output scaled_proc, loop_err);
    modport ctrl  (input strobe, scaled_proc, loop_err);
endinterface
`default_nettype wire

// ---- hdl/spic_tick.sv ----
// Sample period divider producing a one-cycle strobe
// Assumes synchronous active-low reset on ref_clk
`timescale 1ns/1ps
`default_nettype none
module spic_tick #(
    parameter int unsigned DIV = spic_pkg::SAMPLE_CYCLES
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    // Strobe out
    spic_link_if.tick link
);
    import spic_pkg::*;

    localparam logic [31:0] LAST = 32'(DIV - 1);

    typedef struct packed {
        logic [31:0] count;
        logic        strobe;
    } spic_tick_state_t;

    spic_tick_state_t state;
    spic_tick_state_t next_state;

    // Free-running divider, strobe on wrap
    always_comb begin
        next_state = state;
        next_state.strobe = (state.count == LAST);
        next_state.count  = (state.count == LAST) ? '0 : state.count + 32'h1;
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign link.strobe = state.strobe;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_tick_period: assert property (
        state.count == LAST |=> state.strobe && state.count == '0)
        else $error("sample strobe missed its period");
    a_tick_single: assert property (
        state.strobe && DIV > 1 |=> !state.strobe)
        else $error("sample strobe wider than one cycle");
    c_tick_seen: cover property (state.strobe);

endmodule // spic_tick
`default_nettype wire

// ---- hdl/spic_scale.sv ----
// Process value scaling, clamping and loop error
// Assumes gain in hundredths and synchronous inputs
`timescale 1ns/1ps
`default_nettype none
module spic_scale (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          reset_n,
    // Sensor and scaling
    input  wire logic signed [spic_pkg::DW-1:0] process_value,
    input  wire logic signed [spic_pkg::DW-1:0] proc_gain,
    input  wire logic signed [spic_pkg::DW-1:0] proc_offset,
    input  wire logic signed [spic_pkg::DW-1:0] proc_min,
    input  wire logic signed [spic_pkg::DW-1:0] proc_max,
    input  wire logic signed [spic_pkg::DW-1:0] setpoint,
    // Results
    spic_link_if.scale                         link
);
    import spic_pkg::*;

    typedef struct packed {
        logic signed [DW-1:0] scaled;
        logic signed [DW:0]   err;
    } spic_scale_state_t;

    spic_scale_state_t       state;
    spic_scale_state_t       next_state;
    logic signed [ACC_W-1:0] raw;

    // Scale, clamp, then form the loop error
    always_comb begin
        raw = ACC_W'(process_value) * ACC_W'(proc_gain)
            / ACC_W'(GAIN_DIV) + ACC_W'(proc_offset);
        next_state.scaled = DW'(spic_clamp(raw, ACC_W'(proc_min),
                                           ACC_W'(proc_max)));
        next_state.err = (DW+1)'(setpoint)
                       - (DW+1)'(next_state.scaled);
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign link.scaled_proc = state.scaled;
    assign link.loop_err    = state.err;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_scale_form: assert property (
        raw <= ACC_W'(proc_max) && raw >= ACC_W'(proc_min)
        |=> state.scaled == $past(DW'(raw)))
        else $error("scaled value not gain times value plus offset");
    a_clamp_high: assert property (
        raw > ACC_W'(proc_max) && proc_min <= proc_max
        |=> state.scaled == $past(proc_max))
        else $error("scaled value not held at maximum");
    a_clamp_low: assert property (
        raw < ACC_W'(proc_min) && proc_min <= proc_max
        |=> state.scaled == $past(proc_min))
        else $error("scaled value not held at minimum");
    a_err_form: assert property (
        ##1 state.err == (DW+1)'($past(setpoint)) - (DW+1)'(state.scaled))
        else $error("loop error not setpoint minus scaled value");

endmodule // spic_scale
`default_nettype wire

// ---- verif/spic_sensor_model.sv ----
// Sensor model feeding the process value into the controller
// Assumes the bench sets the demanded reading on ref_clk rising edges
`timescale 1ns/1ps
`default_nettype none
module spic_sensor_model (
    // Clock
    input  wire logic                           ref_clk,
    // Demanded reading and sensor line
    input  wire logic signed [spic_pkg::DW-1:0] demand,
    output var  logic signed [spic_pkg::DW-1:0] process_value
);
    // Reading settles one clock after the demand
    always_ff @(posedge ref_clk) begin
        process_value <= demand;
    end
endmodule // spic_sensor_model
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the sampled PI controller top level
// Assumes SAMPLE_DIV of 8 and a 500 manual value as integral seed
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import spic_pkg::*;
    localparam int N = 8;
    logic ref_clk = 1'b0, reset_n = 1'b0, output_reset = 1'b0;
    logic auto_manual_select = 1'b0, action_direction = 1'b1;
    logic auto_active, sample_done;
    logic signed [DW-1:0] demand = '0, setpoint = '0, proc_offset = '0;
    logic signed [DW-1:0] proc_gain = 16'sh0064, process_value;
    logic [GAIN_W-1:0] loop_gain = '0;
    logic [ITIME_W-1:0] integral_time = 13'h0001;
    logic [PSET_W-1:0] preset_sel = '0;
    logic [OUT_W-1:0] manual_output_value = '0, analog_output;
    int num_errors = 0, tests_run = 0, cycles = 0, k;
    // Rows: dir, preset, gain, time, value, setpoint, scale, offset, output
    int rows [17][9] = '{'{1,0,100,1,90,100,100,0,515},
        '{1,0,100,1,110,100,100,0,485}, '{0,0,100,1,90,100,100,0,485},
        '{0,0,100,1,110,100,100,0,515}, '{1,0,100,1,0,1000,100,0,1000},
        '{1,0,100,1,1000,0,100,0,0}, '{1,0,100,1,30000,19990,100,0,485},
        '{1,0,100,1,-20000,-9990,100,0,515}, '{1,0,100,1,40,95,200,5,515},
        '{1,0,100,1,50,50,100,0,500}, '{1,0,0,1,90,100,100,0,505},
        '{0,1,0,9,90,100,100,0,505}, '{0,2,0,9,90,100,100,0,510},
        '{0,3,0,9,90,100,100,0,533}, '{0,4,0,9,90,100,100,0,512},
        '{0,5,0,9,90,100,100,0,515}, '{0,6,0,9,90,100,100,0,507}};

    always #20 ref_clk = ~ref_clk;

    spic_sensor_model spic_sensor_model_inst (.ref_clk(ref_clk),
        .demand(demand), .process_value(process_value));
    spic_top #(.SAMPLE_DIV(N)) spic_top_inst (.ref_clk(ref_clk),
        .reset_n(reset_n), .process_value(process_value),
        .proc_gain(proc_gain), .proc_offset(proc_offset),
        .proc_min(-16'sd10000), .proc_max(16'sd20000), .setpoint(setpoint),
        .loop_gain(loop_gain), .integral_time(integral_time),
        .action_direction(action_direction), .preset_sel(preset_sel),
        .manual_output_value(manual_output_value),
        .auto_manual_select(auto_manual_select),
        .output_reset(output_reset), .analog_output(analog_output),
        .auto_active(auto_active), .sample_done(sample_done));

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %0d expected %0d", $time, seen, exp);
        end
    endtask

    // Count cycles up to the next sample pulse, bounded
    task automatic wait_done();
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (sample_done !== 1'b1 && k < 60);
    endtask

    task automatic give_verdict();
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        check(analog_output, 16'h0000);
        @(posedge ref_clk);
        manual_output_value <= 10'h12C;
        repeat (20) @(negedge ref_clk);
        check(analog_output, 16'h012C);
        @(posedge ref_clk);
        output_reset <= 1'b1;
        auto_manual_select <= 1'b1;
        manual_output_value <= 10'h1F4;
        repeat (20) @(negedge ref_clk);
        check(analog_output, 16'h0000);
        check(auto_active, 16'h0000);
        // Table: reseed from the manual value, then one calculation
        foreach (rows[i]) begin
            @(posedge ref_clk);
            output_reset <= 1'b1;
            action_direction <= rows[i][0][0];
            preset_sel <= rows[i][1][2:0];
            loop_gain <= rows[i][2][13:0];
            integral_time <= rows[i][3][12:0];
            demand <= rows[i][4][15:0];
            setpoint <= rows[i][5][15:0];
            proc_gain <= rows[i][6][15:0];
            proc_offset <= rows[i][7][15:0];
            repeat (2) @(posedge ref_clk);
            output_reset <= 1'b0;
            wait_done();
            check(analog_output, rows[i][8][15:0]);
            check(auto_active, 16'h0001);
        end
        // Spacing of consecutive samples
        wait_done();
        check(k[15:0], N);
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
